// ==== hdl/adder_chain_ctrl.sv ====
// Controller that drives a chain of gated ripple full adder stages.
// Assumes stage outputs arrive asynchronously; they are synchronised here.
`timescale 1ns/1ps

// What this block does
// - Direct inputs low when wired node drives
// - Wired node open when direct inputs drive
// - Even stages inverted operands, complemented sum used
// - Odd stages noninverted operands, true incoming carry
// - Subtract: carry-in one, subtrahend complemented
// - Adder control on odd second inputs, even controls
// - Subtractor control pattern alternates by stage
// - First A plus first B: second controls low
// - Other pairings hold unused controls low
// - Wired selection: even bits complemented
module adder_chain_ctrl #(
  parameter int unsigned WIDTH = adder_ctrl_pkg::CHAIN_WIDTH
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_reg_a1,
  input  wire logic [WIDTH-1:0] i_reg_a2,
  input  wire logic [WIDTH-1:0] i_reg_b1,
  input  wire logic [WIDTH-1:0] i_reg_b2,
  input  wire logic [1:0]       i_sel,
  input  wire logic             i_subtract,
  input  wire logic             i_enable,
  input  wire logic [WIDTH-1:0] i_stage_sum,
  input  wire logic [WIDTH-1:0] i_stage_sum_n,
  input  wire logic             i_stage_carry_n,
  output logic [WIDTH-1:0]      o_first_operand_direct_input_one,
  output logic [WIDTH-1:0]      o_first_operand_direct_input_two,
  output logic [WIDTH-1:0]      o_second_operand_direct_input_one,
  output logic [WIDTH-1:0]      o_second_operand_direct_input_two,
  output logic [WIDTH-1:0]      o_first_operand_control_input,
  output logic [WIDTH-1:0]      o_second_operand_control_input,
  output logic [WIDTH-1:0]      o_a_wired_drive,
  output logic [WIDTH-1:0]      o_a_wired_oe,
  output logic [WIDTH-1:0]      o_b_wired_drive,
  output logic [WIDTH-1:0]      o_b_wired_oe,
  output logic                  o_carry_in,
  output logic [WIDTH-1:0]      o_result,
  output logic                  o_carry_out
);

  // ****************************************
  // Stage pin values
  // ****************************************
  logic [WIDTH-1:0] a1_nxt;
  logic [WIDTH-1:0] a2_nxt;
  logic [WIDTH-1:0] b1_nxt;
  logic [WIDTH-1:0] b2_nxt;
  logic [WIDTH-1:0] ac_nxt;
  logic [WIDTH-1:0] bc_nxt;
  logic [WIDTH-1:0] aw_nxt;
  logic [WIDTH-1:0] awe_nxt;
  logic [WIDTH-1:0] bw_nxt;
  logic [WIDTH-1:0] bwe_nxt;
  logic [WIDTH-1:0] a1_r;
  logic [WIDTH-1:0] a2_r;
  logic [WIDTH-1:0] b1_r;
  logic [WIDTH-1:0] b2_r;
  logic [WIDTH-1:0] ac_r;
  logic [WIDTH-1:0] bc_r;
  logic [WIDTH-1:0] aw_r;
  logic [WIDTH-1:0] awe_r;
  logic [WIDTH-1:0] bw_r;
  logic [WIDTH-1:0] bwe_r;
  logic             cin_r;
  wire              use_a2 = i_sel[1];
  wire              use_b2 = i_sel[0];

  // stage operand gating
  // Stage operand as the stage gates it: NOT(NOT(d1&d2) & c)
  function automatic logic stage_operand(input logic d1, input logic d2,
                                         input logic c);
    stage_operand = ~(~(d1 & d2) & c);
  endfunction

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      // even stages (bit 2,4) inverted data
      logic even;
      logic da, db, ctl_a2, ctl_b2;
      even   = (i % 2) == 1;
      da     = use_a2 ? i_reg_a2[i] : i_reg_a1[i];
      db     = (use_b2 ? i_reg_b2[i] : i_reg_b1[i]) ^ i_subtract;
      // even bits complemented for wired path
      da     = da ^ even;
      db     = db ^ even;
      ctl_a2 = i_enable & use_a2;
      ctl_b2 = i_enable & use_b2;
      if (!even) begin
        // odd: operand = d1 & d2; A control held high, B control high on add and i_enable on subtract
        a1_nxt[i] = ~use_a2 & da;
        a2_nxt[i] = ~use_a2 & i_enable;
        b1_nxt[i] = ~use_b2 & db;
        b2_nxt[i] = ~use_b2 & (i_subtract ? 1'b1 : i_enable);
        ac_nxt[i] = 1'b1;
        bc_nxt[i] = i_subtract ? i_enable : 1'b1;
      end else begin
        // Even: operand = ~(d1&d2) & ctl inverted again by stage
        a1_nxt[i] = ~use_a2 & da;
        a2_nxt[i] = ~use_a2;
        b1_nxt[i] = ~use_b2 & db;
        b2_nxt[i] = ~use_b2 & (i_subtract ? i_enable : 1'b1);
        ac_nxt[i] = i_enable;
        bc_nxt[i] = i_subtract ? 1'b1 : i_enable;
      end
      // wired node driven only when selected
      aw_nxt[i]  = ~(da & ctl_a2);
      awe_nxt[i] = use_a2;
      bw_nxt[i]  = ~(db & ctl_b2);
      bwe_nxt[i] = use_b2;
      // disable forces stage sums low: odd stages clear direct input one, even A control, add B control and subtract B direct input two follow i_enable
      if (!i_enable && !even) begin
        a1_nxt[i] = 1'b0;
        b1_nxt[i] = 1'b0;
      end
    end
  end

  // ****************************************
  // Result capture
  // ****************************************
  logic [WIDTH-1:0] s_m_r;
  logic [WIDTH-1:0] s_r;
  logic [WIDTH-1:0] sn_m_r;
  logic [WIDTH-1:0] sn_r;
  logic [WIDTH-1:0] res_r;
  logic             c_m_r;
  logic             c_r;
  logic             cout_r;
  logic [WIDTH-1:0] res_nxt;
  logic             model_unused;

  always_comb begin
    res_nxt      = '0;
    model_unused = stage_operand(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < WIDTH; i++) begin
      res_nxt[i] = (i % 2 == 1) ? sn_r[i] : s_r[i];
    end
  end

  // top carry polarity by chain parity
  wire cout_nxt = (WIDTH % 2 == 1) ? ~c_r : c_r;

  // ****************************************
  // Pin registers
  // ****************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {a1_r, a2_r, b1_r, b2_r}   <= '0;
      {ac_r, bc_r}               <= '0;
      {aw_r, awe_r, bw_r, bwe_r} <= '0;
    end else begin
      {a1_r, a2_r, b1_r, b2_r}   <= {a1_nxt, a2_nxt, b1_nxt, b2_nxt};
      {ac_r, bc_r}               <= {ac_nxt, bc_nxt};
      {aw_r, awe_r, bw_r, bwe_r} <= {aw_nxt, awe_nxt, bw_nxt, bwe_nxt};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cin_r <= adder_ctrl_pkg::RST_LEVEL;
    end else begin
      cin_r <= i_subtract ? adder_ctrl_pkg::CARRY_SUB : adder_ctrl_pkg::CARRY_ADD;
    end
  end

  // ****************************************
  // Stage output synchronisers
  // ****************************************
  // stages settle without clock
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {s_m_r, s_r}   <= '0;
      {sn_m_r, sn_r} <= '0;
      {c_m_r, c_r}   <= '0;
    end else begin
      s_m_r  <= i_stage_sum;
      s_r    <= s_m_r;
      sn_m_r <= i_stage_sum_n;
      sn_r   <= sn_m_r;
      c_m_r  <= i_stage_carry_n;
      c_r    <= c_m_r;
    end
  end

  // Corrected result registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      res_r  <= '0;
      cout_r <= 1'b0;
    end else begin
      res_r  <= res_nxt;
      cout_r <= cout_nxt;
    end
  end

  assign o_first_operand_direct_input_one  = a1_r;
  assign o_first_operand_direct_input_two  = a2_r;
  assign o_second_operand_direct_input_one = b1_r;
  assign o_second_operand_direct_input_two = b2_r;
  assign o_first_operand_control_input     = ac_r;
  assign o_second_operand_control_input    = bc_r;
  assign o_a_wired_drive                   = aw_r;
  assign o_a_wired_oe                      = awe_r;
  assign o_b_wired_drive                   = bw_r;
  assign o_b_wired_oe                      = bwe_r;
  assign o_carry_in                        = cin_r;
  assign o_result                          = res_r;
  assign o_carry_out                       = cout_r;

endmodule // adder_chain_ctrl

// ==== hdl/adder_ctrl_pkg.sv ====
// Constants for the ripple adder chain controller.
// Assumes a chain of gated full adder stages outside, bit 1 lowest.
package adder_ctrl_pkg;
  localparam int unsigned CHAIN_WIDTH = 4;
  localparam logic        RST_LEVEL   = 1'b0;
  localparam logic        CARRY_SUB   = 1'b1;
  localparam logic        CARRY_ADD   = 1'b0;
  localparam logic [1:0]  SEL_A1_B1   = 2'h0;
  localparam logic [1:0]  SEL_A1_B2   = 2'h1;
  localparam logic [1:0]  SEL_A2_B1   = 2'h2;
  localparam logic [1:0]  SEL_A2_B2   = 2'h3;
endpackage

// ==== bench/adder_chain_ctrl_props.sv ====
// Port checker for the adder chain controller, bound to its top module.
`timescale 1ns/1ps
module adder_chain_ctrl_chk #(parameter int unsigned WIDTH = 4) (
  input wire logic i_sys_clk, i_rst_n, i_subtract, i_enable, o_carry_in,
  input wire logic [1:0] i_sel,
  input wire logic [WIDTH-1:0] o_first_operand_direct_input_one, o_first_operand_control_input,
  input wire logic [WIDTH-1:0] o_first_operand_direct_input_two, o_second_operand_control_input,
  input wire logic [WIDTH-1:0] o_second_operand_direct_input_one, o_a_wired_oe,
  input wire logic [WIDTH-1:0] o_second_operand_direct_input_two, o_b_wired_oe, o_result);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  property p_cin; $past(i_rst_n) |-> o_carry_in == $past(i_subtract); endproperty
  a_cin: assert property (p_cin) else $error("carry in wrong");
  property p_alow;
  (o_a_wired_oe & (o_first_operand_direct_input_one | o_first_operand_direct_input_two)) == '0;
  endproperty
  a_alow: assert property (p_alow) else $error("A direct not low");
  property p_blow;
  (o_b_wired_oe & (o_second_operand_direct_input_one | o_second_operand_direct_input_two)) == '0;
  endproperty
  a_blow: assert property (p_blow) else $error("B direct not low");
  property p_asel; $past(i_rst_n) && $past(i_enable) |-> (|o_a_wired_oe) == $past(i_sel[1]);
  endproperty
  a_asel: assert property (p_asel) else $error("A select wrong");
  property p_bsel; $past(i_rst_n) && $past(i_enable) |-> (|o_b_wired_oe) == $past(i_sel[0]);
  endproperty
  a_bsel: assert property (p_bsel) else $error("B select wrong");
  property p_add; $past(i_rst_n) && !$past(i_subtract) && $past(i_sel) == 2'h0 |->
    {o_first_operand_direct_input_two[0], o_second_operand_direct_input_two[0],
     o_first_operand_control_input[1], o_second_operand_control_input[1]} == {4{$past(i_enable)}};
  endproperty
  a_add: assert property (p_add) else $error("adder gating wrong");
  property p_sub; $past(i_rst_n) && $past(i_subtract) && $past(i_sel) == 2'h0 |->
    {o_first_operand_direct_input_two[0], o_second_operand_control_input[0],
     o_first_operand_control_input[1], o_second_operand_direct_input_two[1]} == {4{$past(i_enable)}};
  endproperty
  a_sub: assert property (p_sub) else $error("subtract gating wrong");
  property p_off; (i_enable == 1'b0) [*5] |=> o_result == '0; endproperty
  a_off: assert property (p_off) else $error("sum not forced low");
  c_sub: cover property (i_subtract && i_enable);
  c_wired: cover property (|o_a_wired_oe && |o_b_wired_oe);
  c_off: cover property ((i_enable == 1'b0) [*5]);
endmodule // adder_chain_ctrl_chk
bind adder_chain_ctrl adder_chain_ctrl_chk #(.WIDTH(WIDTH)) adder_chain_ctrl_chk_inst (.*);

// ==== bench/stage_chain_model.sv ====
// Behavioural chain of gated full adder stages; index 0 is the lowest stage.
`timescale 1ns/1ps
module stage_chain_model #(parameter int W = 4) (
  input  wire logic [W-1:0] i_a1, i_a2, i_b1, i_b2, i_ac, i_bc, i_ad, i_ae, i_bd, i_be,
  input  wire logic         i_cin,
  output logic [W-1:0]      o_sum, o_sum_n,
  output logic              o_cout_n);
  logic [W:0]   c;
  logic [W-1:0] an, bn, a, b;
  assign an = ~(i_a1 & i_a2) & (~i_ae | i_ad);
  assign bn = ~(i_b1 & i_b2) & (~i_be | i_bd);
  assign a = ~(an & i_ac);
  assign b = ~(bn & i_bc);
  assign c[0] = i_cin;
  for (genvar k = 0; k < W; k++) begin : g_stage
    assign c[k+1] = ~((a[k] & b[k]) | (c[k] & (a[k] ^ b[k])));
  end
  assign o_sum = a ^ b ^ c[W-1:0];
  assign o_sum_n = ~o_sum;
  assign o_cout_n = c[W];
endmodule // stage_chain_model

// ==== bench/adder_chain_ctrl_tb.sv ====
// Bench: controller driving a behavioural stage chain, results queued and compared.
`timescale 1ns/1ps
module adder_chain_ctrl_tb;
  localparam int W = adder_ctrl_pkg::CHAIN_WIDTH;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_subtract = 1'b0, i_enable = 1'b0;
  logic [1:0] i_sel = 2'h0;
  logic [W-1:0] i_reg_a1 = '0, i_reg_a2 = '0, i_reg_b1 = '0, i_reg_b2 = '0, o_result;
  logic i_stage_carry_n, o_carry_in, o_carry_out;
  logic [W-1:0] i_stage_sum, i_stage_sum_n, o_a_wired_drive, o_a_wired_oe, o_b_wired_drive;
  logic [W-1:0] o_b_wired_oe, o_first_operand_direct_input_one, o_first_operand_direct_input_two;
  logic [W-1:0] o_second_operand_direct_input_one, o_second_operand_direct_input_two;
  logic [W-1:0] o_first_operand_control_input, o_second_operand_control_input;
  int failures = 0, n_checks = 0;
  logic [W+1:0] q[$];
  logic [W+1:0] e;
  event smp;
  always #5 i_sys_clk = ~i_sys_clk;
  adder_chain_ctrl #(.WIDTH(W)) adder_chain_ctrl_inst (.*);
  stage_chain_model #(.W(W)) stage_chain_model_inst (
    .i_a1(o_first_operand_direct_input_one), .i_a2(o_first_operand_direct_input_two),
    .i_b1(o_second_operand_direct_input_one), .i_b2(o_second_operand_direct_input_two),
    .i_ac(o_first_operand_control_input), .i_bc(o_second_operand_control_input),
    .i_ad(o_a_wired_drive), .i_ae(o_a_wired_oe), .i_bd(o_b_wired_drive), .i_be(o_b_wired_oe),
    .i_cin(o_carry_in), .o_sum(i_stage_sum), .o_sum_n(i_stage_sum_n), .o_cout_n(i_stage_carry_n));
  task automatic chk(string n, logic [W-1:0] x, logic [W-1:0] g);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Operand pick, add or subtract, queued expectation
  task automatic op(logic en, logic sb);
    logic [W:0] a, b, s;
    @(negedge i_sys_clk);
    {i_reg_a1, i_reg_a2, i_reg_b1, i_reg_b2} = (4*W)'($urandom);
    i_sel = 2'($urandom);
    i_enable = en;
    i_subtract = sb;
    a = {1'b0, i_sel[1] ? i_reg_a2 : i_reg_a1};
    b = {1'b0, i_sel[0] ? i_reg_b2 : i_reg_b1};
    s = sb ? a + {1'b0, ~b[W-1:0]} + (W+1)'(1) : a + b;
    q.push_back({en, s[W], en ? s[W-1:0] : W'(0)});
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    -> smp;
  endtask
  always @(smp) begin
    e = q.pop_front();
    chk("result", e[W-1:0], o_result);
    if (e[W+1]) chk("carry", W'(e[W]), W'(o_carry_out));
  end
  initial begin
    void'($urandom(32'hd20c));
    repeat (16) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    for (int t = 0; t < 3; t++) begin
      repeat (16) op(t != 2, t == 1);
      $display("test %0d done", t);
    end
    final_report;
  end
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    failures++;
    final_report;
  end
endmodule // adder_chain_ctrl_tb
